//--- core/asr_cfg.svh
// Constants for the alert source status register block.
// Assumes it is included by bare name from the package and design files.
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

`define ASR_OFFSET      8'h20
`define ASR_RESET_VALUE 8'h80
`define ASR_BIT_UNASSIGNED 7
`define ASR_BIT_PARITY  6
`define ASR_BIT_ECC     5
`define ASR_BIT_FORCE   4
`define ASR_BIT_OVERHEAT 3
`define ASR_BIT_SLEEP   2
`define ASR_BIT_OTB     1
`define ASR_BIT_OTA     0
`define ASR_W1C_MASK    8'h6F
`define ASR_ZERO        8'h00

`endif

//--- core/asr_pkg.sv
// Types shared by the alert source status register block.
// Assumes asr_cfg.svh sits on the include path.
`include "asr_cfg.svh"

package asr_pkg;
   typedef logic [7:0] asr_byte_t;   // One register byte
   typedef logic [7:0] asr_addr_t;   // Register address
endpackage

//--- core/asr_status.sv
// Alert source status register with warning output and summary bit.
// Assumes a simple synchronous register port from the serial interface
// and synchronous condition inputs from the rest of the device.
//
// Contract
// - Bit 7 is forced to 1 while the address-assigned control bit is 0.
// - Bit 7 clears only after address assigned, then host writes 1, then 0.
// - Bit 7 reads 1 after reset, 0 only once the clear sequence completes.
// - Bit 6 sets when protected configuration group fails validation.
// - Bit 5 sets on uncorrectable OTP double-bit error, not on corrected single.
// - Bit 4 written 1 forces warning, 0 releases; resets to 0.
// - Bit 3 sets while die temperature exceeds shutdown threshold; default 0.
// - Bit 2 sets only on sleep entry; stays clear while sleep stays set.
// - Bit 1 sets when sensor B over trip; 0 when disabled.
// - Bit 0 sets when sensor A over trip; 0 when disabled.
// - All flags but bits 7 and 4 clear on write 1; bit 4 freely written.
// - Any set flag drives warning output and main status summary bit.
`timescale 1ns/100ps
`include "asr_cfg.svh"

module asr_status
(
   input  wire logic              sys_clk,          // Core clock, 250 MHz
   input  wire logic              reset,            // Async reset, active high
   input  wire logic              ce,               // Clock enable
   input  wire logic              reg_wr,           // Register write strobe
   input  wire logic              reg_rd,           // Register read strobe
   input  wire asr_pkg::asr_addr_t reg_addr,        // Register address
   input  wire asr_pkg::asr_byte_t reg_wdata,       // Write data
   output asr_pkg::asr_byte_t     reg_rdata,        // Read data, registered
   input  wire logic              address_assigned, // Address control bit
   input  wire logic              config_invalid,   // Protected group check failed
   input  wire logic              ecc_double_err,   // Uncorrectable OTP error
   input  wire logic              die_overheat,     // Die above shutdown temp
   input  wire logic              sleep_ctrl,       // Sleep control bit
   input  wire logic              sensor_a_over,    // Sensor A above trip level
   input  wire logic              sensor_b_over,    // Sensor B above trip level
   input  wire logic              sensor_a_input_enable, // Sensor A enable
   input  wire logic              sensor_b_input_enable, // Sensor B enable
   output logic                   warning_out,      // Warning output, high active
   output logic                   warning_summary   // Main status summary bit
);
   import asr_pkg::*;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   asr_byte_t  sticky;
   asr_byte_t  status;
   logic       address_unassigned_flag;
   logic       clr_armed;
   logic       force_warn;
   logic       sleep_prev;

   wire logic      wr_hit     = reg_wr && (reg_addr == `ASR_OFFSET);
   wire logic      rd_hit     = reg_rd && (reg_addr == `ASR_OFFSET);
   wire asr_byte_t wr_ones    = wr_hit ? reg_wdata : `ASR_ZERO;
   wire logic      sleep_rise = sleep_ctrl && !sleep_prev;
   wire logic      addr_wr1   = wr_hit && reg_wdata[`ASR_BIT_UNASSIGNED];
   wire logic      addr_wr0   = wr_hit && !reg_wdata[`ASR_BIT_UNASSIGNED];

   // Set vector; bits 7 and 4 are not sticky flags
   asr_byte_t set_vec;
   asr_byte_t clr_vec;
   always_comb
   begin
      set_vec                  = `ASR_ZERO;
      set_vec[`ASR_BIT_PARITY] = config_invalid;
      set_vec[`ASR_BIT_ECC]    = ecc_double_err;
      set_vec[`ASR_BIT_OVERHEAT] = die_overheat;
      set_vec[`ASR_BIT_SLEEP]  = sleep_rise;
      set_vec[`ASR_BIT_OTB]    = sensor_b_over && sensor_b_input_enable;
      set_vec[`ASR_BIT_OTA]    = sensor_a_over && sensor_a_input_enable;
      clr_vec                  = wr_ones & `ASR_W1C_MASK;
      clr_vec[`ASR_BIT_OTB]    = wr_ones[`ASR_BIT_OTB] || !sensor_b_input_enable;
      clr_vec[`ASR_BIT_OTA]    = wr_ones[`ASR_BIT_OTA] || !sensor_a_input_enable;
   end

   asr_sticky #(.W(8)) u_sticky
   (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ce      (ce),
      .set_vec (set_vec),
      .clr_vec (clr_vec),
      .flags   (sticky)
   );

   // Readable byte as the host sees it
   always_comb
   begin
      status                  = sticky;
      status[`ASR_BIT_UNASSIGNED] = address_unassigned_flag;
      status[`ASR_BIT_FORCE]  = force_warn;
   end

   // -----------------------------------------------------------------
   // Address flag, force bit and sleep edge
   // -----------------------------------------------------------------
   // Arming needs the address first, so a 1-then-0 pair written before
   // assignment never clears the flag; losing the address re-raises it
   wire logic next_clr_armed       = !address_assigned ? 1'b0 :
                                     addr_wr1 ? 1'b1 : (addr_wr0 ? 1'b0 : clr_armed);
   wire logic next_unassigned_flag = !address_assigned ? 1'b1 :
                                     (clr_armed && addr_wr0) ? 1'b0 :
                                     address_unassigned_flag;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         address_unassigned_flag <= 1'b1;
         clr_armed               <= 1'b0;
         force_warn              <= 1'b0;
         sleep_prev              <= 1'b0;
      end
      else if (ce)
      begin
         address_unassigned_flag <= next_unassigned_flag;
         clr_armed               <= next_clr_armed;
         if (wr_hit)
            force_warn <= reg_wdata[`ASR_BIT_FORCE];
         sleep_prev              <= sleep_ctrl;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Warning follows the byte one cycle later; force is part of the byte
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         warning_out     <= 1'b0;
         warning_summary <= 1'b0;
         reg_rdata       <= `ASR_ZERO;
      end
      else if (ce)
      begin
         warning_out     <= |status;
         warning_summary <= |status;
         reg_rdata       <= rd_hit ? status : `ASR_ZERO;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // Address flag: forced while unassigned, cleared only by the armed pair
   a_flag_follows_addr: assert property (@(posedge sys_clk) disable iff (reset)
      ce && !address_assigned |=> address_unassigned_flag)
      else $error("unassigned flag not raised");
   a_flag_needs_seq: assert property (@(posedge sys_clk) disable iff (reset)
      ce && address_unassigned_flag && !(clr_armed && addr_wr0) |=> address_unassigned_flag)
      else $error("unassigned flag cleared without sequence");
   a_flag_clears: assert property (@(posedge sys_clk) disable iff (reset)
      ce && address_assigned && clr_armed && addr_wr0 |=> !address_unassigned_flag)
      else $error("unassigned flag not cleared by sequence");

   // Register port: read data stands one cycle and is zero otherwise
   a_rdata_read: assert property (@(posedge sys_clk) disable iff (reset)
      ce && rd_hit |=> reg_rdata == $past(status))
      else $error("read data differs from status byte");
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
      ce && !rd_hit |=> reg_rdata == `ASR_ZERO)
      else $error("read data not zero without read");

   // Sticky flags; set must win even when a clear lands in the same cycle
   a_parity_set: assert property (@(posedge sys_clk) disable iff (reset)
      ce && config_invalid |=> status[`ASR_BIT_PARITY])
      else $error("parity flag not set");
   a_ecc_set: assert property (@(posedge sys_clk) disable iff (reset)
      ce && ecc_double_err |=> status[`ASR_BIT_ECC])
      else $error("ecc flag not set");
   a_force_write: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_hit |=> force_warn == $past(reg_wdata[`ASR_BIT_FORCE]))
      else $error("force bit not written");
   a_force_hold: assert property (@(posedge sys_clk) disable iff (reset)
      ce && !wr_hit |=> $stable(force_warn))
      else $error("force bit changed without write");
   a_sleep_rise: assert property (@(posedge sys_clk) disable iff (reset)
      ce && sleep_rise |=> status[`ASR_BIT_SLEEP])
      else $error("sleep flag not set on entry");
   a_sleep_edge: assert property (@(posedge sys_clk) disable iff (reset)
      ce && sleep_prev && sleep_ctrl && !status[`ASR_BIT_SLEEP] |=> !status[`ASR_BIT_SLEEP])
      else $error("sleep flag re-raised");
   // Sensor flags: set only while enabled, wiped when disabled
   a_ota_set: assert property (@(posedge sys_clk) disable iff (reset)
      ce && sensor_a_over && sensor_a_input_enable |=> status[`ASR_BIT_OTA])
      else $error("sensor a flag not set");
   a_otb_set: assert property (@(posedge sys_clk) disable iff (reset)
      ce && sensor_b_over && sensor_b_input_enable |=> status[`ASR_BIT_OTB])
      else $error("sensor b flag not set");
   a_ota_disabled: assert property (@(posedge sys_clk) disable iff (reset)
      ce && !sensor_a_input_enable |=> !status[`ASR_BIT_OTA])
      else $error("sensor a flag set while disabled");
   a_otb_disabled: assert property (@(posedge sys_clk) disable iff (reset)
      ce && !sensor_b_input_enable |=> !status[`ASR_BIT_OTB])
      else $error("sensor b flag set while disabled");
   a_overheat_set: assert property (@(posedge sys_clk) disable iff (reset)
      ce && die_overheat |=> status[`ASR_BIT_OVERHEAT])
      else $error("die overheat flag not set");
   a_w1c_clear: assert property (@(posedge sys_clk) disable iff (reset)
      ce && wr_hit && reg_wdata[`ASR_BIT_ECC] && !ecc_double_err |=> !status[`ASR_BIT_ECC])
      else $error("ecc flag not cleared by write");
   a_warn_level: assert property (@(posedge sys_clk) disable iff (reset)
      ce |=> warning_out == $past(|status))
      else $error("warning does not follow flags");
   a_warn_release: assert property (@(posedge sys_clk) disable iff (reset)
      ce && force_warn |=> warning_out)
      else $error("warning released while forced");

   // Warning pin and summary bit; a frozen clock enable must not drop them
   a_warn_off: assert property (@(posedge sys_clk) disable iff (reset)
      ce && (status == `ASR_ZERO) |=> !warning_out)
      else $error("warning held with no flag set");
   a_summary_match: assert property (@(posedge sys_clk) disable iff (reset)
      warning_summary == warning_out)
      else $error("summary bit differs from warning");
   a_ce_freeze: assert property (@(posedge sys_clk) disable iff (reset)
      !ce |=> $stable(warning_out) && $stable(reg_rdata) && $stable(sticky))
      else $error("state moved while clock enable low");
endmodule // asr_status

//--- core/asr_sticky.sv
// Bank of sticky flags: set inputs win over clear inputs in the same cycle.
// Assumes synchronous set and clear vectors and one clock domain.
`timescale 1ns/100ps
`include "asr_cfg.svh"

module asr_sticky
#(
   parameter int W = 8                     // Number of flags
)
(
   input  wire logic         sys_clk,      // Core clock
   input  wire logic         reset,        // Async reset, active high
   input  wire logic         ce,           // Clock enable, freezes state
   input  wire logic [W-1:0] set_vec,      // Flags to set
   input  wire logic [W-1:0] clr_vec,      // Flags to clear
   output logic      [W-1:0] flags         // Current flags
);
   // -----------------------------------------------------------------
   // Flag storage
   // -----------------------------------------------------------------
   wire logic [W-1:0] next_flags = (flags & ~clr_vec) | set_vec;

   // Set is or-ed in last so an event coinciding with a clear survives
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         flags <= '0;
      else if (ce)
         flags <= next_flags;
   end
endmodule // asr_sticky

//--- dv/asr_host_model.sv
// Host model for the alert source register port: one access per clock cycle.
// Assumes the bench calls cycle() once per cycle; signals change on the falling edge.
`timescale 1ns/100ps

module asr_host_model
(
   input  wire logic         sys_clk,    // Core clock
   output logic              reg_wr,     // Write strobe
   output logic              reg_rd,     // Read strobe
   output asr_pkg::asr_addr_t reg_addr,  // Register address
   output asr_pkg::asr_byte_t reg_wdata  // Write data
);
   import asr_pkg::*;

   // ----------------------------------------
   // Bus cycle
   // ----------------------------------------
   // Idle cycles invert address and data, so a stale value is never trusted
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // One strobe lasts exactly one cycle; back to back is allowed
   task automatic cycle(input logic wr, input logic rd, input asr_addr_t a, input asr_byte_t d);
      @(negedge sys_clk);
      reg_wr    <= wr;
      reg_rd    <= rd;
      reg_addr  <= (wr | rd) ? a : ~reg_addr;
      reg_wdata <= wr ? d : ~reg_wdata;
   endtask
endmodule // asr_host_model

//--- dv/tb_alert_source_status_register.sv
// Self-checking bench for the alert source status register.
// Assumes the core files and the host model are compiled before it.
`timescale 1ns/100ps
`include "asr_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, a, b); end end

module tb_alert_source_status_register;
   import asr_pkg::*;
   logic      sys_clk = 1'b0, reset = 1'b1, ce = 1'b1, address_assigned = 1'b0;
   logic      config_invalid = 1'b0, ecc_double_err = 1'b0, die_overheat = 1'b0;
   logic      sleep_ctrl = 1'b0, sensor_a_over = 1'b0, sensor_b_over = 1'b0;
   logic      sensor_a_input_enable = 1'b0, sensor_b_input_enable = 1'b0;
   logic      reg_wr, reg_rd, warning_out, warning_summary, m_arm, m_slp, m_warn;
   asr_addr_t reg_addr;
   asr_byte_t reg_wdata, reg_rdata, m_byte, m_rdata;
   logic      wr_hit, rd_hit;
   logic [31:0] rnd = 32'h0000_5fbf, r2;
   int        err_count = 0, num_checks = 0;

   asr_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   asr_status uut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .address_assigned(address_assigned), .config_invalid(config_invalid),
      .ecc_double_err(ecc_double_err), .die_overheat(die_overheat), .sleep_ctrl(sleep_ctrl),
      .sensor_a_over(sensor_a_over), .sensor_b_over(sensor_b_over),
      .sensor_a_input_enable(sensor_a_input_enable),
      .sensor_b_input_enable(sensor_b_input_enable),
      .warning_out(warning_out), .warning_summary(warning_summary));

   // ----------------------------------------
   // Reference model of the status byte
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Set inputs win over a same-cycle clear, as in the design
   function automatic asr_byte_t next_byte(input logic w);
      asr_byte_t n;
      n = m_byte & ~(w ? (reg_wdata & `ASR_W1C_MASK) : `ASR_ZERO);
      if (w) n[4] = reg_wdata[4];
      n[6] = n[6] | config_invalid;
      n[5] = n[5] | ecc_double_err;
      n[3] = n[3] | die_overheat;
      n[2] = n[2] | (sleep_ctrl & ~m_slp);
      n[1] = sensor_b_input_enable & (n[1] | sensor_b_over);
      n[0] = sensor_a_input_enable & (n[0] | sensor_a_over);
      if (!address_assigned) n[7] = 1'b1;
      else if (w & ~reg_wdata[7] & m_arm) n[7] = 1'b0;
      return n;
   endfunction

   assign wr_hit = reg_wr & (reg_addr == `ASR_OFFSET);
   assign rd_hit = reg_rd & (reg_addr == `ASR_OFFSET);

   // Clock enable low freezes the whole model, read data included
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         m_byte  <= `ASR_RESET_VALUE;
         m_rdata <= `ASR_ZERO;
         m_arm   <= 1'b0;
         m_slp   <= 1'b0;
         m_warn  <= 1'b0;
      end
      else if (ce)
      begin
         m_byte  <= next_byte(wr_hit);
         m_arm   <= address_assigned & (wr_hit ? reg_wdata[7] : m_arm);
         m_slp   <= sleep_ctrl;
         m_rdata <= rd_hit ? m_byte : `ASR_ZERO;
         m_warn  <= |m_byte;
      end
   end

   // Outputs are settled by the falling edge
   always @(negedge sys_clk)
   begin
      `CHK(reg_rdata, m_rdata)
      `CHK(warning_out, m_warn)
      `CHK(warning_summary, m_warn)
   end

   task automatic results;
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Directed cases, then random traffic
   // ----------------------------------------
   initial
   begin
      repeat (6) @(negedge sys_clk);
      reset <= 1'b0;
      host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h80);
      host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h00);
      address_assigned = 1'b1;
      repeat (2)
      begin
         host.cycle(1'b0, 1'b1, `ASR_OFFSET, 8'h00);
         host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h80);
         host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h00);
         host.cycle(1'b0, 1'b1, `ASR_OFFSET, 8'h00);
         address_assigned = 1'b0;
         host.cycle(1'b0, 1'b1, `ASR_OFFSET, 8'h00);
         address_assigned = 1'b1;
      end
      sleep_ctrl = 1'b1;
      host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h10);
      host.cycle(1'b1, 1'b0, `ASR_OFFSET, 8'h04);
      host.cycle(1'b0, 1'b1, `ASR_OFFSET, 8'h00);
      host.cycle(1'b0, 1'b1, 8'h21, 8'h00);
      repeat (3000)
      begin
         rnd = xs(rnd);
         r2  = xs(rnd);
         // Bit 7 of random writes stays 0 so the arming sequence is only run on purpose
         host.cycle(rnd[0] & rnd[1], rnd[0] & ~rnd[1], rnd[2] ? `ASR_OFFSET : rnd[15:8],
            {1'b0, rnd[22:16]});
         config_invalid        = (r2[3:0] == 4'h0);
         ecc_double_err        = (r2[7:4] == 4'h0);
         die_overheat          = (r2[11:8] == 4'h0);
         sleep_ctrl            = sleep_ctrl ^ (r2[14:12] == 3'h0);
         sensor_a_over         = r2[15];
         sensor_b_over         = r2[16];
         sensor_a_input_enable = r2[17];
         sensor_b_input_enable = r2[18];
         ce                    = (r2[21:19] != 3'h0);
      end
      // Quiet host and inputs so the read after reset shows the reset byte only
      host.cycle(1'b0, 1'b0, `ASR_OFFSET, 8'h00);
      ce             = 1'b1;
      sleep_ctrl     = 1'b0;
      config_invalid = 1'b0;
      ecc_double_err = 1'b0;
      die_overheat   = 1'b0;
      sensor_a_over  = 1'b0;
      sensor_b_over  = 1'b0;
      reset <= 1'b1;
      repeat (2) @(negedge sys_clk);
      reset <= 1'b0;
      repeat (4) host.cycle(1'b0, 1'b1, `ASR_OFFSET, 8'h00);
      host.cycle(1'b0, 1'b0, `ASR_OFFSET, 8'h00);
      `CHK(reg_rdata, `ASR_RESET_VALUE)
      `CHK(warning_out, 1'b1)
      results();
   end
endmodule // tb_alert_source_status_register
